// *** verilog/tlvic_consts.svh ***
// Constants for the two-level vectored interrupt controller.
`ifndef TLVIC_CONSTS_SVH
`define TLVIC_CONSTS_SVH
// ==========================================================
// Register addresses and reset values
`define TLVIC_ADDR_EN 8'ha8
`define TLVIC_ADDR_EN2 8'ha9
`define TLVIC_ADDR_LVL 8'hb8
`define TLVIC_RST_EN 8'h00
`define TLVIC_RST_EN2 8'ha0
`define TLVIC_RST_LVL 8'h00
// ==========================================================
// Field positions
`define TLVIC_MASTER_BIT 7
`define TLVIC_RSVD_BIT 7
`define TLVIC_EN2_MUSTZ_BIT 3
`define TLVIC_EN2_TI_EN 2
`define TLVIC_EN2_PSM_EN 1
`define TLVIC_EN2_SER_EN 0
`define TLVIC_EN2_TI_LVL 6
`define TLVIC_EN2_PSM_LVL 5
`define TLVIC_EN2_SER_LVL 4
`define TLVIC_BIT_EXT0 0
`define TLVIC_BIT_TMR0 1
`define TLVIC_BIT_EXT1 2
`define TLVIC_BIT_TMR1 3
`define TLVIC_BIT_UART 4
`define TLVIC_BIT_TMR2 5
`define TLVIC_BIT_CONV 6
`define TLVIC_MASK_LVL 8'h7f
`define TLVIC_MASK_EN2 8'hf7
// ==========================================================
// Source count and vector addresses in polling order
`define TLVIC_NSRC 11
`define TLVIC_VEC_PSM 16'h0043
`define TLVIC_VEC_WDOG 16'h005b
`define TLVIC_VEC_EXT0 16'h0003
`define TLVIC_VEC_CONV 16'h0033
`define TLVIC_VEC_TMR0 16'h000b
`define TLVIC_VEC_EXT1 16'h0013
`define TLVIC_VEC_TMR1 16'h001b
`define TLVIC_VEC_SER 16'h003b
`define TLVIC_VEC_UART 16'h0023
`define TLVIC_VEC_TMR2 16'h002b
`define TLVIC_VEC_TI 16'h0053
`endif

// *** verilog/tlvic_pkg.sv ***
// Types shared by the interrupt controller files.
package tlvic_pkg;
  // Requests in polling order, bit 10 highest priority.
  typedef struct packed {
    logic supply_mon_request;
    logic wdog_request;
    logic ext0_request;
    logic conv_request;
    logic tmr0_overflow;
    logic ext1_request;
    logic tmr1_overflow;
    logic serial_port_b_request;
    logic uart_rx_tx_request;
    logic tmr2_request;
    logic interval_request;
  } tlvic_req_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
  } tlvic_sfr_t;
  typedef enum logic [2:0] {
    TLVIC_IDLE = 3'b001,
    TLVIC_LOW = 3'b010,
    TLVIC_HIGH = 3'b100
  } tlvic_state_t;
endpackage

// *** verilog/tlvic_pick.sv ***
// Fixed-order picker returning the first set bit from the top.
`timescale 1ns/1ps
`include "tlvic_consts.svh"
module tlvic_pick (
  input wire logic [`TLVIC_NSRC-1:0] req,
  output logic any,
  output logic [3:0] idx
);
  // ==========================================================
  // Priority search
  // fixed polling order
  always_comb begin
    any = 1'b0;
    idx = 4'h0;
    for (int i = 0; i < `TLVIC_NSRC; i++) begin
      if (req[i]) begin
        any = 1'b1;
        idx = 4'(i);
      end
    end
  end
endmodule

// *** verilog/tlvic_ctrl.sv ***
// Two-level vectored interrupt controller with its three registers.
// Notes on behaviour
// - Enable bit 7 gates all sources; when zero nothing is accepted.
// - Enable bits 6..0: converter, timer2, uart, timer1, ext1, timer0, ext0.
// - Level register bits 6..0 same order, 1 high; bit 7 reserved.
// - Second register enables interval bit 2, supply bit 1, serial bit 0.
// - Second register levels interval bit 6, supply bit 5, serial bit 4.
// - Enabled high request preempts a running low handler at once.
// - Same-cycle requests of different levels: high level granted first.
// - A handler is never preempted by a request of its own level.
// - Same-level order: supply, wdog, ext0, conv, t0, ext1, t1, serial...
// - On accept core pushes PC and loads the granted vector.
// - Vectors 0003, 000B, 0013, 001B, 0023, 002B for classic sources.
// - Vectors 0033, 003B, 0043, 0053, 005B for added sources.
`timescale 1ns/1ps
`include "tlvic_consts.svh"
module tlvic_ctrl (
  input wire logic clk,
  input wire logic srst,
  input wire tlvic_pkg::tlvic_req_t req,
  input wire tlvic_pkg::tlvic_sfr_t sfr,
  input wire logic core_ack,
  input wire logic core_reti,
  output logic [7:0] sfr_rdata,
  output logic irq_take,
  output logic [15:0] irq_vector,
  output logic [1:0] active_levels
);
  // ==========================================================
  // Registers
  logic [7:0] irq_enable_reg;
  logic [7:0] irq_enable_level_reg2;
  logic [7:0] irq_level_reg;
  tlvic_pkg::tlvic_state_t state;
  logic in_high;
  logic in_low;

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_enable_reg <= `TLVIC_RST_EN;
    end else if (sfr.wr && sfr.addr == `TLVIC_ADDR_EN) begin
      irq_enable_reg <= sfr.wdata;
    end
  end

  // level register, reserved bit stays zero
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_level_reg <= `TLVIC_RST_LVL;
    end else if (sfr.wr && sfr.addr == `TLVIC_ADDR_LVL) begin
      irq_level_reg <= sfr.wdata & `TLVIC_MASK_LVL;
    end
  end

  // second register write; bit 3 is stored as zero.
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_enable_level_reg2 <= `TLVIC_RST_EN2;
    end else if (sfr.wr && sfr.addr == `TLVIC_ADDR_EN2) begin
      irq_enable_level_reg2 <= sfr.wdata & `TLVIC_MASK_EN2;
    end
  end

  // Reserved bit 7 of the second register keeps what was written.
  always_ff @(posedge clk) begin
    if (srst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr.addr == `TLVIC_ADDR_EN) begin
      sfr_rdata <= irq_enable_reg;
    end else if (sfr.addr == `TLVIC_ADDR_EN2) begin
      sfr_rdata <= irq_enable_level_reg2;
    end else if (sfr.addr == `TLVIC_ADDR_LVL) begin
      sfr_rdata <= irq_level_reg;
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // Enables and levels laid out in polling order
  logic [`TLVIC_NSRC-1:0] src_en;
  logic [`TLVIC_NSRC-1:0] src_lvl;
  logic [`TLVIC_NSRC-1:0] gated;
  logic [`TLVIC_NSRC-1:0] hi_req;
  logic [`TLVIC_NSRC-1:0] lo_req;
  logic [`TLVIC_NSRC-1:0] req_vec;
  logic hi_any;
  logic lo_any;
  logic [3:0] hi_idx;
  logic [3:0] lo_idx;

  // Bit 0 of these vectors is the lowest priority source; the packed
  // request struct already lists its fields in that order.
  always_comb begin
    for (int i = 0; i < `TLVIC_NSRC; i++) begin
      req_vec[i] = req[i];
    end
  end

  assign src_en = {
    irq_enable_level_reg2[`TLVIC_EN2_PSM_EN], 1'b1,
    irq_enable_reg[`TLVIC_BIT_EXT0], irq_enable_reg[`TLVIC_BIT_CONV],
    irq_enable_reg[`TLVIC_BIT_TMR0], irq_enable_reg[`TLVIC_BIT_EXT1],
    irq_enable_reg[`TLVIC_BIT_TMR1],
    irq_enable_level_reg2[`TLVIC_EN2_SER_EN],
    irq_enable_reg[`TLVIC_BIT_UART], irq_enable_reg[`TLVIC_BIT_TMR2],
    irq_enable_level_reg2[`TLVIC_EN2_TI_EN]};
  // The watchdog has no level bit, so it always sits at high level.
  assign src_lvl = {
    irq_enable_level_reg2[`TLVIC_EN2_PSM_LVL], 1'b1,
    irq_level_reg[`TLVIC_BIT_EXT0], irq_level_reg[`TLVIC_BIT_CONV],
    irq_level_reg[`TLVIC_BIT_TMR0], irq_level_reg[`TLVIC_BIT_EXT1],
    irq_level_reg[`TLVIC_BIT_TMR1],
    irq_enable_level_reg2[`TLVIC_EN2_SER_LVL],
    irq_level_reg[`TLVIC_BIT_UART], irq_level_reg[`TLVIC_BIT_TMR2],
    irq_enable_level_reg2[`TLVIC_EN2_TI_LVL]};

  assign gated = req_vec & src_en &
    {`TLVIC_NSRC{irq_enable_reg[`TLVIC_MASTER_BIT]}};
  assign hi_req = gated & src_lvl;
  assign lo_req = gated & ~src_lvl;

  tlvic_pick u_hi (
    .req(hi_req),
    .any(hi_any),
    .idx(hi_idx)
  );
  tlvic_pick u_lo (
    .req(lo_req),
    .any(lo_any),
    .idx(lo_idx)
  );

  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    case (idx)
      4'ha: vec_of = `TLVIC_VEC_PSM;
      4'h9: vec_of = `TLVIC_VEC_WDOG;
      4'h8: vec_of = `TLVIC_VEC_EXT0;
      4'h7: vec_of = `TLVIC_VEC_CONV;
      4'h6: vec_of = `TLVIC_VEC_TMR0;
      4'h5: vec_of = `TLVIC_VEC_EXT1;
      4'h4: vec_of = `TLVIC_VEC_TMR1;
      4'h3: vec_of = `TLVIC_VEC_SER;
      4'h2: vec_of = `TLVIC_VEC_UART;
      4'h1: vec_of = `TLVIC_VEC_TMR2;
      default: vec_of = `TLVIC_VEC_TI;
    endcase
  endfunction

  // ==========================================================
  // Arbitration
  logic grant_hi;
  logic grant_lo;
  assign grant_hi = hi_any && !in_high && !irq_take;
  assign grant_lo = lo_any && !hi_any && !in_high && !in_low &&
    !irq_take;

  // The request stays up until the core acknowledges, so a vector
  // is never lost while the core finishes its current instruction.
  // vector offered to core
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_take <= 1'b0;
      irq_vector <= 16'h0000;
    end else if (irq_take) begin
      if (core_ack) begin
        irq_take <= 1'b0;
      end
    end else if (grant_hi) begin
      irq_take <= 1'b1;
      irq_vector <= vec_of(hi_idx);
    end else if (grant_lo) begin
      irq_take <= 1'b1;
      irq_vector <= vec_of(lo_idx);
    end
  end

  logic take_hi;
  always_ff @(posedge clk) begin
    if (srst) begin
      take_hi <= 1'b0;
    end else if (!irq_take && (grant_hi || grant_lo)) begin
      take_hi <= grant_hi;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      in_high <= 1'b0;
      in_low <= 1'b0;
      state <= tlvic_pkg::TLVIC_IDLE;
    end else if (irq_take && core_ack) begin
      if (take_hi) begin
        in_high <= 1'b1;
        state <= tlvic_pkg::TLVIC_HIGH;
      end else begin
        in_low <= 1'b1;
        state <= tlvic_pkg::TLVIC_LOW;
      end
    end else if (core_reti) begin
      case (state)
        tlvic_pkg::TLVIC_HIGH: begin
          in_high <= 1'b0;
          state <= in_low ? tlvic_pkg::TLVIC_LOW : tlvic_pkg::TLVIC_IDLE;
        end
        tlvic_pkg::TLVIC_LOW: begin
          in_low <= 1'b0;
          state <= tlvic_pkg::TLVIC_IDLE;
        end
        default: begin
          state <= tlvic_pkg::TLVIC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      active_levels <= 2'b00;
    end else begin
      active_levels <= {in_high, in_low};
    end
  end
endmodule

// *** testbench/tlvic_ctrl_assertions.sv ***
// Port checker for the interrupt controller.
`timescale 1ns/1ps
module tlvic_ctrl_assertions (
  input wire logic clk,
  input wire logic srst,
  input wire tlvic_pkg::tlvic_req_t req,
  input wire tlvic_pkg::tlvic_sfr_t sfr,
  input wire logic core_ack,
  input wire logic core_reti,
  input wire logic [7:0] sfr_rdata,
  input wire logic irq_take,
  input wire logic [15:0] irq_vector,
  input wire logic [1:0] active_levels
);
  localparam logic [175:0] VT = {16'h43, 16'h5b, 16'h03, 16'h33, 16'h0b,
    16'h13, 16'h1b, 16'h3b, 16'h23, 16'h2b, 16'h53};
  logic [7:0] enr, lv, e2, rd;
  logic [10:0] en, hl, pd, hi;
  logic [15:0] wv, hv;
  logic calm;
  // Later set bits override, so the top pending source wins.
  function automatic logic [15:0] vec(input logic [10:0] w);
    vec = 16'h0;
    for (int i = 0; i < 11; i++) begin
      if (w[i]) vec = VT[16*i +: 16];
    end
  endfunction
  // ====
  // Register mirror
  always_ff @(posedge clk) begin
    calm <= !core_ack && !core_reti;
    if (srst) begin
      enr <= 8'h00;
      e2 <= 8'ha0;
      lv <= 8'h00;
    end else if (sfr.wr) begin
      case (sfr.addr)
        8'ha8: enr <= sfr.wdata;
        8'ha9: e2 <= sfr.wdata & 8'hf7;
        8'hb8: lv <= sfr.wdata & 8'h7f;
        default: ;
      endcase
    end
  end
  always_comb begin
    case (sfr.addr)
      8'ha8: rd = enr;
      8'ha9: rd = e2;
      8'hb8: rd = lv;
      default: rd = 8'h00;
    endcase
  end
  assign en = {e2[1], 1'b1, enr[0], enr[6], enr[1], enr[2], enr[3], e2[0],
    enr[4], enr[5], e2[2]};
  assign hl = {e2[5], 1'b1, lv[0], lv[6], lv[1], lv[2], lv[3], e2[4],
    lv[4], lv[5], e2[6]};
  assign pd = req & en & {11{enr[7]}};
  assign hi = pd & hl;
  assign wv = vec((|hi) ? hi : pd);
  assign hv = vec(hi);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_master_gate: assert property (
    !irq_take && !enr[7] |=> !irq_take) else $error("gate");
  a_take_holds: assert property (
    irq_take && !core_ack |=> irq_take && $stable(irq_vector))
    else $error("offer dropped");
  a_ack_drops: assert property (
    irq_take && core_ack |=> !irq_take) else $error("offer stuck");
  a_grant_order: assert property (
    !irq_take && calm && active_levels == 2'b00 && |pd
    |=> irq_take && irq_vector == $past(wv)) else $error("order");
  a_high_preempts: assert property (
    !irq_take && calm && active_levels == 2'b01 && |hi
    |=> irq_take && irq_vector == $past(hv)) else $error("preempt");
  a_same_level: assert property (
    !irq_take && calm && (active_levels[1] || active_levels[0] && !(|hi))
    |=> !irq_take) else $error("same level");
  a_reti_release: assert property (
    core_reti && !irq_take && calm && active_levels == 2'b01
    |-> ##2 active_levels == 2'b00) else $error("release");
  a_reg_readback: assert property (
    !sfr.wr |=> sfr_rdata == $past(rd)) else $error("readback");
endmodule
bind tlvic_ctrl tlvic_ctrl_assertions chk_u (.clk(clk), .srst(srst),
  .req(req), .sfr(sfr), .core_ack(core_ack), .core_reti(core_reti),
  .sfr_rdata(sfr_rdata), .irq_take(irq_take), .irq_vector(irq_vector),
  .active_levels(active_levels));

// *** testbench/tlvic_core_model.sv ***
// Core model that takes offered vectors and returns from handlers.
`timescale 1ns/1ps
module tlvic_core_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic irq_take,
  input wire logic [15:0] irq_vector,
  input wire logic [3:0] dly,
  input wire logic reti_req,
  output logic core_ack,
  output logic core_reti,
  output logic [15:0] pc
);
  logic [3:0] cnt;
  always_ff @(posedge clk) begin
    if (srst || !irq_take || core_ack) begin
      core_ack <= 1'b0;
      cnt <= 4'h0;
    end else if (cnt == dly) begin
      core_ack <= 1'b1;
      pc <= irq_vector;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    core_reti <= reti_req && !srst;
  end
endmodule

// *** testbench/tlvic_ctrl_tb.sv ***
// Self-checking bench for the interrupt controller.
`timescale 1ns/1ps
module tlvic_ctrl_tb;
  logic clk, srst, ack, reti, take, rr;
  logic [3:0] dly;
  logic [7:0] rdata;
  logic [15:0] vec, pc;
  logic [1:0] act;
  tlvic_pkg::tlvic_req_t req;
  tlvic_pkg::tlvic_sfr_t sfr;
  int err_total, n_checks, i;
  logic [15:0] vt [11] = '{16'h5b, 16'h43, 16'h03, 16'h33, 16'h0b, 16'h13,
    16'h1b, 16'h3b, 16'h23, 16'h2b, 16'h53};
  int bt [11] = '{9, 10, 8, 7, 6, 5, 4, 3, 2, 1, 0};
  tlvic_ctrl dut_u (.clk(clk), .srst(srst), .req(req), .sfr(sfr),
    .core_ack(ack), .core_reti(reti), .sfr_rdata(rdata),
    .irq_take(take), .irq_vector(vec), .active_levels(act));
  tlvic_core_model core_u (.clk(clk), .srst(srst), .irq_take(take),
    .irq_vector(vec), .dly(dly), .reti_req(rr), .core_ack(ack),
    .core_reti(reti), .pc(pc));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task test_done();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // A bounded wait, so a silent controller ends the run.
  task automatic wt(input bit use_ack);
    for (int k = 0; k < 40 && (use_ack ? ack : take) !== 1'b1; k++) begin
      @(negedge clk);
    end
    if ((use_ack ? ack : take) !== 1'b1) begin
      err_total++;
      test_done();
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr <= '{a, d, 1'b1};
    @(posedge clk);
    sfr <= '{a, d, 1'b0};
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfr <= '{a, 8'h00, 1'b0};
    @(posedge clk);
    @(negedge clk);
    chk({8'h00, rdata}, {8'h00, e});
  endtask
  task serve(input logic [15:0] e, input int b);
    wt(1'b0);
    chk(vec, e);
    wt(1'b1);
    chk(pc, e);
    @(posedge clk);
    req[b] <= 1'b0;
  endtask
  task ret();
    @(posedge clk);
    rr <= 1'b1;
    dly <= dly + 4'h1;
    @(posedge clk);
    rr <= 1'b0;
    repeat (3) @(negedge clk);
  endtask
  initial begin
    srst = 1'b1;
    req = '0;
    sfr = '0;
    rr = 1'b0;
    dly = 4'h0;
    err_total = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(8'ha8, 8'h00);
    rd(8'ha9, 8'ha0);
    rd(8'h55, 8'h00);
    wr(8'hb8, 8'hff);
    rd(8'hb8, 8'h7f);
    wr(8'ha9, 8'hff);
    rd(8'ha9, 8'hf7);
    wr(8'ha9, 8'h07);
    wr(8'hb8, 8'h00);
    wr(8'ha8, 8'h7f);
    req <= '1;
    repeat (8) @(negedge clk);
    chk({15'h0, take}, 16'h0);
    wr(8'ha8, 8'hff);
    for (i = 0; i < 11; i++) begin
      serve(vt[i], bt[i]);
      ret();
    end
    wr(8'hb8, 8'h01);
    req <= 11'h040;
    serve(16'h000b, 6);
    @(posedge clk);
    req <= 11'h110;
    serve(16'h0003, 8);
    repeat (2) @(negedge clk);
    chk({14'h0, act}, 16'h3);
    ret();
    chk({14'h0, act}, 16'h1);
    chk({15'h0, take}, 16'h0);
    ret();
    serve(16'h001b, 4);
    ret();
    test_done();
  end
endmodule
